// ==== pldc_cfg.sv ====
`timescale 1ns/1ps
module pldc_cfg #(
  parameter int NUM_LDEV = 4,
  parameter int LDEV_W = 2,
  parameter int IO_SPAN = 8,
  parameter bit IRQ_TYPE_FIXED = 1'b0
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [LDEV_W-1:0] cfg_ldn,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_index,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [15:0] io_addr,
  output logic [7:0] io_rdata,
  output logic io_rdata_oe,
  output logic [NUM_LDEV-1:0] dev_sel,
  output logic [NUM_LDEV-1:0] dev_active,
  output logic [NUM_LDEV-1:0] dev_irq_level_mode,
  input wire logic [NUM_LDEV-1:0] dev_irq,
  input wire logic [NUM_LDEV-1:0] dev_drq0,
  input wire logic [NUM_LDEV-1:0] dev_drq1,
  output logic [15:0] interrupt_line_level_o,
  output logic [15:0] interrupt_line_level_oe,
  output logic [7:0] drq_o
);

  typedef struct packed {
    pldc_pkg::pldc_dev_s [NUM_LDEV-1:0] dev;
    logic [NUM_LDEV-1:0] irq_prev;
    logic [NUM_LDEV-1:0][pldc_pkg::PU_W-1:0] pu_cnt;
    logic [7:0] cfg_rdata;
    logic [7:0] io_rdata;
    logic io_oe;
  } pldc_state_s;

  pldc_state_s st_r;
  pldc_state_s st_nxt;

  // True when addr falls in [base, base + IO_SPAN)
  function automatic logic in_range(input logic [15:0] addr,
                                    input logic [10:0] base);
    logic [16:0] lo;
    logic [16:0] hi;
    lo = {6'h00, base};
    hi = lo + 17'(IO_SPAN);
    in_range = ({1'b0, addr} >= lo) && ({1'b0, addr} < hi);
  endfunction : in_range

  // DMA select value to one-hot channel, cascade gives none
  function automatic logic [7:0] dma_onehot(input logic [2:0] sel);
    dma_onehot = (sel == pldc_pkg::DMA_CASCADE) ? 8'h00 : 8'(1) << sel;
  endfunction : dma_onehot

  function automatic logic [7:0] read_reg(input pldc_pkg::pldc_dev_s d,
                                          input logic [7:0] idx);
    logic [7:0] v;
    v = pldc_pkg::BYTE_ZERO;
    case (idx)
      pldc_pkg::IDX_ACTIVATE: v[pldc_pkg::BIT_ACT] = d.act;
      pldc_pkg::IDX_CONFLICT:
      begin
        v[pldc_pkg::BIT_CHK_PAT] = d.chk_pat;
        v[pldc_pkg::BIT_CHK_EN] = d.chk_en;
      end
      pldc_pkg::IDX_BASE0_HI: v[2:0] = d.base0[10:8];
      pldc_pkg::IDX_BASE0_LO: v = d.base0[7:0];
      pldc_pkg::IDX_BASE1_HI: v[2:0] = d.base1[10:8];
      pldc_pkg::IDX_BASE1_LO: v = d.base1[7:0];
      pldc_pkg::IDX_IRQ_LVL: v[3:0] = d.irq_lvl;
      pldc_pkg::IDX_IRQ_TYPE:
      begin
        v[pldc_pkg::BIT_IRQ_TYPE] = d.irq_type;
        v[pldc_pkg::BIT_IRQ_POL] = d.irq_pol;
      end
      pldc_pkg::IDX_DMA0: v[2:0] = d.dma0;
      pldc_pkg::IDX_DMA1: v[2:0] = d.dma1;
      default: v = pldc_pkg::BYTE_ZERO;
    endcase
    read_reg = v;
  endfunction : read_reg

  // Per-device address decode and check response
  logic [NUM_LDEV-1:0] hit;
  logic [NUM_LDEV-1:0] chk_hit;

  genvar g;
  generate
    for (g = 0; g < NUM_LDEV; g++)
    begin : g_dec
      assign hit[g] = in_range(io_addr, st_r.dev[g].base0) ||
                      in_range(io_addr, st_r.dev[g].base1);
      // Check answer only while inactive
      assign chk_hit[g] = hit[g] && st_r.dev[g].chk_en && !st_r.dev[g].act;
      // Inactive and unchecked devices stay silent
      assign dev_sel[g] = hit[g] && st_r.dev[g].act && (io_rd || io_wr);
      assign dev_active[g] = st_r.dev[g].act;
      assign dev_irq_level_mode[g] = st_r.dev[g].irq_type;
    end
  endgenerate

  always_comb
  begin
    pldc_pkg::pldc_dev_s d;
    logic [LDEV_W-1:0] ld;
    d = st_r.dev[0];
    ld = cfg_ldn;
    st_nxt = st_r;
    st_nxt.irq_prev = dev_irq;
    st_nxt.io_oe = 1'b0;
    st_nxt.io_rdata = pldc_pkg::BYTE_ZERO;

    // Configuration reads and writes reach only the selected device
    if (32'(ld) < NUM_LDEV)
    begin
      d = st_r.dev[ld];
      if (cfg_rd)
        st_nxt.cfg_rdata = read_reg(d, cfg_index);
      if (cfg_wr)
      begin
        case (cfg_index)
          pldc_pkg::IDX_ACTIVATE:
            d.act = cfg_wdata[pldc_pkg::BIT_ACT];
          pldc_pkg::IDX_CONFLICT:
          begin
            d.chk_pat = cfg_wdata[pldc_pkg::BIT_CHK_PAT];
            d.chk_en = cfg_wdata[pldc_pkg::BIT_CHK_EN];
          end
          pldc_pkg::IDX_BASE0_HI:
            d.base0[10:8] = cfg_wdata[pldc_pkg::BASE_HI_W-1:0];
          pldc_pkg::IDX_BASE0_LO: d.base0[7:0] = cfg_wdata;
          pldc_pkg::IDX_BASE1_HI:
            d.base1[10:8] = cfg_wdata[pldc_pkg::BASE_HI_W-1:0];
          pldc_pkg::IDX_BASE1_LO: d.base1[7:0] = cfg_wdata;
          pldc_pkg::IDX_IRQ_LVL: d.irq_lvl = cfg_wdata[3:0];
          pldc_pkg::IDX_IRQ_TYPE:
            // A single-type device keeps its reset value
            if (!IRQ_TYPE_FIXED)
            begin
              d.irq_type = cfg_wdata[pldc_pkg::BIT_IRQ_TYPE];
              d.irq_pol = cfg_wdata[pldc_pkg::BIT_IRQ_POL];
            end
          pldc_pkg::IDX_DMA0: d.dma0 = cfg_wdata[2:0];
          pldc_pkg::IDX_DMA1: d.dma1 = cfg_wdata[2:0];
          default: ;
        endcase
        st_nxt.dev[ld] = d;
      end
    end
    else if (cfg_rd)
      st_nxt.cfg_rdata = pldc_pkg::BYTE_ZERO;

    // Range check answers; lowest device wins if ranges overlap
    if (io_rd)
    begin
      for (int i = NUM_LDEV - 1; i >= 0; i--)
      begin
        if (chk_hit[i])
        begin
          st_nxt.io_oe = 1'b1;
          st_nxt.io_rdata = st_r.dev[i].chk_pat ? pldc_pkg::CHK_PAT1
                                                : pldc_pkg::CHK_PAT0;
        end
      end
    end

    // Strong pull-up timer starts when an active-low request is released
    for (int i = 0; i < NUM_LDEV; i++)
    begin
      if (st_r.irq_prev[i] && !dev_irq[i])
        st_nxt.pu_cnt[i] = pldc_pkg::PU_W'(pldc_pkg::PULLUP_CYC);
      else if (dev_irq[i])
        st_nxt.pu_cnt[i] = '0;
      else if (st_r.pu_cnt[i] != '0)
        st_nxt.pu_cnt[i] = st_r.pu_cnt[i] - pldc_pkg::PU_W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r.dev <= {NUM_LDEV{pldc_pkg::DEV_RST}};
      st_r.irq_prev <= '0;
      st_r.pu_cnt <= '0;
      st_r.cfg_rdata <= pldc_pkg::BYTE_ZERO;
      st_r.io_rdata <= pldc_pkg::BYTE_ZERO;
      st_r.io_oe <= 1'b0;
    end
    else
      st_r <= st_nxt;
  end

  assign cfg_rdata = st_r.cfg_rdata;
  assign io_rdata = st_r.io_rdata;
  assign io_rdata_oe = st_r.io_oe;

  // Interrupt pins; a device drives only while active with a level chosen
  always_comb
  begin
    interrupt_line_level_o = '0;
    interrupt_line_level_oe = '0;
    for (int i = 0; i < NUM_LDEV; i++)
    begin
      if (st_r.dev[i].act && st_r.dev[i].irq_lvl != pldc_pkg::IRQ_NONE)
      begin
        if (st_r.dev[i].irq_pol)
        begin
          // Push-pull, active high
          interrupt_line_level_oe[st_r.dev[i].irq_lvl] = 1'b1;
          interrupt_line_level_o[st_r.dev[i].irq_lvl] = dev_irq[i];
        end
        // The prev term bridges the cycle before the timer is loaded
        else if (dev_irq[i] || st_r.irq_prev[i] || st_r.pu_cnt[i] != '0)
        begin
          // Open-drain low; brief drive high speeds the release
          interrupt_line_level_oe[st_r.dev[i].irq_lvl] = 1'b1;
          interrupt_line_level_o[st_r.dev[i].irq_lvl] = !dev_irq[i];
        end
      end
    end
  end

  // DMA requests of active devices to their channels
  always_comb
  begin
    drq_o = '0;
    for (int i = 0; i < NUM_LDEV; i++)
    begin
      if (st_r.dev[i].act)
      begin
        if (dev_drq0[i])
          drq_o = drq_o | dma_onehot(st_r.dev[i].dma0);
        if (dev_drq1[i])
          drq_o = drq_o | dma_onehot(st_r.dev[i].dma1);
      end
    end
  end

endmodule : pldc_cfg

// ==== pldc_pkg.sv ====
package pldc_pkg;

  // Configuration indexes
  localparam logic [7:0] IDX_ACTIVATE = 8'h30;
  localparam logic [7:0] IDX_CONFLICT = 8'h31;
  localparam logic [7:0] IDX_BASE0_HI = 8'h60;
  localparam logic [7:0] IDX_BASE0_LO = 8'h61;
  localparam logic [7:0] IDX_BASE1_HI = 8'h62;
  localparam logic [7:0] IDX_BASE1_LO = 8'h63;
  localparam logic [7:0] IDX_IRQ_LVL = 8'h70;
  localparam logic [7:0] IDX_IRQ_TYPE = 8'h71;
  localparam logic [7:0] IDX_DMA0 = 8'h74;
  localparam logic [7:0] IDX_DMA1 = 8'h75;

  // Field positions
  localparam int BIT_ACT = 0;
  localparam int BIT_CHK_PAT = 0;
  localparam int BIT_CHK_EN = 1;
  localparam int BIT_IRQ_TYPE = 0;
  localparam int BIT_IRQ_POL = 1;
  localparam int BASE_HI_W = 3;

  // Fixed values
  localparam logic [7:0] CHK_PAT0 = 8'hAA;
  localparam logic [7:0] CHK_PAT1 = 8'h55;
  localparam logic [2:0] DMA_CASCADE = 3'h4;
  localparam logic [3:0] IRQ_NONE = 4'h0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // Reset values
  localparam logic [10:0] RST_BASE = 11'h000;
  localparam logic [3:0] RST_IRQ_LVL = 4'h0;
  localparam logic RST_IRQ_TYPE = 1'b0;
  localparam logic RST_IRQ_POL = 1'b0;
  localparam logic [2:0] RST_DMA = 3'h4;

  // Strong pull-up phase of an active-low open-drain interrupt
  localparam int PULLUP_NS = 80;
  localparam int CLK_NS = 40;
  localparam int PULLUP_CYC = (PULLUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int PU_W = $clog2(PULLUP_CYC + 1);

  typedef struct packed {
    logic act;
    logic chk_en;
    logic chk_pat;
    logic [10:0] base0;
    logic [10:0] base1;
    logic [3:0] irq_lvl;
    logic irq_type;
    logic irq_pol;
    logic [2:0] dma0;
    logic [2:0] dma1;
  } pldc_dev_s;

  localparam pldc_dev_s DEV_RST = '{
    act: 1'b0, chk_en: 1'b0, chk_pat: 1'b0,
    base0: RST_BASE, base1: RST_BASE,
    irq_lvl: RST_IRQ_LVL, irq_type: RST_IRQ_TYPE, irq_pol: RST_IRQ_POL,
    dma0: RST_DMA, dma1: RST_DMA};

endpackage : pldc_pkg

// ==== pldc_cfg_asserts.sv ====
`timescale 1ns/1ps
module pldc_cfg_asserts #(
  parameter int NUM_LDEV = 4,
  parameter int LDEV_W = 2
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [LDEV_W-1:0] cfg_ldn,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_index,
  input wire logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [7:0] io_rdata,
  input wire logic io_rdata_oe,
  input wire logic [NUM_LDEV-1:0] dev_sel,
  input wire logic [NUM_LDEV-1:0] dev_active,
  input wire logic [15:0] interrupt_line_level_oe,
  input wire logic [7:0] drq_o
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence s_act_wr;
    cfg_wr && cfg_index == 8'h30 && cfg_ldn < NUM_LDEV;
  endsequence
  sequence s_hi_rd;
    cfg_rd && (cfg_index == 8'h60 || cfg_index == 8'h62);
  endsequence
  property p_act;
    s_act_wr |=> {7'h00, dev_active[$past(cfg_ldn)]} ==
      ($past(cfg_wdata) & 8'h01);
  endproperty
  a_act: assert property (p_act) else $error("activate bit lost");
  property p_act_rsv;
    cfg_rd && cfg_index == 8'h30 |=> cfg_rdata[7:1] == 7'h00;
  endproperty
  a_act_rsv: assert property (p_act_rsv) else $error("bits set");
  property p_chk_rsv;
    cfg_rd && cfg_index == 8'h31 |=> cfg_rdata[7:2] == 6'h00;
  endproperty
  a_chk_rsv: assert property (p_chk_rsv) else $error("bits set");
  property p_hi_rsv;
    s_hi_rd |=> cfg_rdata[7:3] == 5'h00;
  endproperty
  a_hi_rsv: assert property (p_hi_rsv) else $error("high set");
  property p_pat;
    io_rdata_oe |-> $past(io_rd) && (io_rdata == 8'hAA || io_rdata == 8'h55);
  endproperty
  a_pat: assert property (p_pat) else $error("bad answer");
  property p_oe_end;
    !io_rd |=> !io_rdata_oe;
  endproperty
  a_oe_end: assert property (p_oe_end) else $error("stray answer");
  property p_sel;
    |dev_sel |-> (io_rd || io_wr) && (dev_sel & ~dev_active) == '0;
  endproperty
  a_sel: assert property (p_sel) else $error("bad select");
  property p_fixed;
    nrst |-> !drq_o[4] && !interrupt_line_level_oe[0];
  endproperty
  a_fixed: assert property (p_fixed) else $error("driven");
endmodule : pldc_cfg_asserts

bind pldc_cfg pldc_cfg_asserts #(.NUM_LDEV(NUM_LDEV), .LDEV_W(LDEV_W)) i_chk (
  .clk_sys, .nrst, .cfg_ldn, .cfg_wr, .cfg_rd, .cfg_index, .cfg_wdata,
  .cfg_rdata, .io_rd, .io_wr, .io_rdata, .io_rdata_oe, .dev_sel, .dev_active,
  .interrupt_line_level_oe, .drq_o);

// ==== pldc_host.sv ====
`timescale 1ns/1ps
module pldc_host (
  input wire logic clk_sys,
  output logic [1:0] cfg_ldn,
  output logic cfg_wr,
  output logic cfg_rd,
  output logic [7:0] cfg_index,
  output logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata,
  output logic io_rd,
  output logic [15:0] io_addr,
  input wire logic [7:0] io_rdata,
  input wire logic io_rdata_oe
);
  initial
  begin
    {cfg_ldn, cfg_wr, cfg_rd, cfg_index, cfg_wdata, io_rd} = '0;
    io_addr = 16'hFFFF;
  end
  task automatic wr(input logic [1:0] l, input logic [7:0] i, d);
    @(posedge clk_sys);
    cfg_ldn <= l;
    cfg_index <= i;
    cfg_wdata <= d;
    cfg_wr <= 1'b1;
    @(posedge clk_sys);
    cfg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] l, input logic [7:0] i,
    output logic [15:0] d);
    @(posedge clk_sys);
    cfg_ldn <= l;
    cfg_index <= i;
    cfg_rd <= 1'b1;
    @(posedge clk_sys);
    cfg_rd <= 1'b0;
    #1 d = {8'h00, cfg_rdata};
  endtask : rd
  task automatic io(input logic [15:0] a, output logic [15:0] r);
    @(posedge clk_sys);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge clk_sys);
    io_rd <= 1'b0;
    io_addr <= ~a;
    #1 r = {7'h00, io_rdata_oe, io_rdata};
  endtask : io
endmodule : pldc_host

// ==== test_pnp_logical_device_config.sv ====
`timescale 1ns/1ps
module test_pnp_logical_device_config;
  localparam logic [7:0] IDX [10] = '{8'h30, 8'h31, 8'h60, 8'h61, 8'h62,
    8'h63, 8'h70, 8'h71, 8'h74, 8'h75};
  localparam logic [7:0] MSK [10] = '{8'h01, 8'h03, 8'h07, 8'hFF, 8'h07,
    8'hFF, 8'h0F, 8'h03, 8'h07, 8'h07};
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic io_wr = 1'b0;
  logic [1:0] cfg_ldn;
  logic cfg_wr, cfg_rd, io_rd, io_rdata_oe;
  logic [7:0] cfg_index, cfg_wdata, cfg_rdata, io_rdata, drq_o;
  logic [15:0] io_addr, r, interrupt_line_level_o, interrupt_line_level_oe;
  logic [3:0] dev_sel, dev_active, dev_irq_level_mode;
  logic [3:0] dev_irq = '0, dev_drq0 = '0, dev_drq1 = '0;
  int bad_count = 0;
  int checks_done = 0;
  pldc_cfg i_dut (.clk_sys, .nrst, .cfg_ldn, .cfg_wr, .cfg_rd, .cfg_index,
    .cfg_wdata, .cfg_rdata, .io_rd, .io_wr, .io_addr, .io_rdata, .io_rdata_oe,
    .dev_sel, .dev_active, .dev_irq_level_mode, .dev_irq, .dev_drq0,
    .dev_drq1, .interrupt_line_level_o, .interrupt_line_level_oe, .drq_o);
  pldc_host i_host (.clk_sys, .cfg_ldn, .cfg_wr, .cfg_rd, .cfg_index,
    .cfg_wdata, .cfg_rdata, .io_rd, .io_addr, .io_rdata, .io_rdata_oe);
  initial
  begin
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [15:0] got, exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict
  initial
  begin
    #100000;
    bad_count++;
    give_verdict();
  end
  initial
  begin
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    for (int i = 0; i < 10; i++)
    begin
      i_host.rd(2'd1, IDX[i], r);
      chk(r, (i > 7) ? 16'h0004 : 16'h0000);
      i_host.wr(2'd1, IDX[i], 8'hFF);
      i_host.rd(2'd1, IDX[i], r);
      chk(r, {8'h00, MSK[i]});
    end
    i_host.rd(2'd1, 8'h40, r);
    chk(r, 16'h0000);
    i_host.rd(2'd0, 8'h61, r);
    chk(r, 16'h0000);
    $display("test registers done");
    i_host.wr(2'd1, 8'h30, 8'h00);
    i_host.wr(2'd1, 8'h60, 8'h01);
    i_host.wr(2'd1, 8'h61, 8'h20);
    i_host.wr(2'd1, 8'h31, 8'h02);
    i_host.io(16'h0120, r);
    chk(r, 16'h01AA);
    i_host.wr(2'd1, 8'h31, 8'h03);
    i_host.io(16'h0127, r);
    chk(r, 16'h0155);
    i_host.io(16'h0803, r);
    chk(r, 16'h0155);
    i_host.io(16'h0128, r);
    chk(r >> 8, 16'h0000);
    i_host.wr(2'd1, 8'h31, 8'h00);
    i_host.io(16'h0120, r);
    chk(r >> 8, 16'h0000);
    i_host.wr(2'd1, 8'h30, 8'h01);
    #1 chk({12'h000, dev_active}, 16'h0002);
    i_host.wr(2'd1, 8'h31, 8'h02);
    i_host.io(16'h0120, r);
    chk(r >> 8, 16'h0000);
    $display("test range check done");
    dev_drq0 <= 4'h2;
    for (int c = 0; c < 8; c++)
    begin
      i_host.wr(2'd1, 8'h74, 8'(c));
      #1 chk({8'h00, drq_o}, (c == 4) ? 16'h0000 : 16'(1 << c));
    end
    dev_drq1 <= 4'h2;
    i_host.wr(2'd1, 8'h75, 8'h03);
    #1 chk({8'h00, drq_o}, 16'h0088);
    $display("test dma done");
    i_host.wr(2'd1, 8'h70, 8'h05);
    i_host.wr(2'd1, 8'h71, 8'h03);
    dev_irq <= 4'h2;
    @(posedge clk_sys);
    #1 chk(interrupt_line_level_oe & interrupt_line_level_o, 16'h0020);
    chk({15'h0000, dev_irq_level_mode[1]}, 16'h0001);
    i_host.wr(2'd1, 8'h71, 8'h00);
    #1 chk({interrupt_line_level_oe[5], interrupt_line_level_o[5]}, 2'b10);
    dev_irq <= 4'h0;
    #1 chk({interrupt_line_level_oe[5], interrupt_line_level_o[5]}, 2'b11);
    repeat (6) @(posedge clk_sys);
    #1 chk(interrupt_line_level_oe, 16'h0000);
    i_host.wr(2'd1, 8'h71, 8'h02);
    i_host.wr(2'd1, 8'h70, 8'h00);
    dev_irq <= 4'h2;
    @(posedge clk_sys);
    #1 chk(interrupt_line_level_oe, 16'h0000);
    $display("test interrupt done");
    give_verdict();
  end
endmodule : test_pnp_logical_device_config
